// ===== verilog/offset_dac_code_control.sv
// offset code holding, default loading and gain-change reload for both channel groups
//
// Contract
// - two independent 14-bit offset codes, one per group
// - defaults 2666h gain six, 2AABh gain four
// - trimmed default may deviate three counts
// - reset loads defaults for format and gain
// - gain change reloads both codes with defaults
// - larger code shifts group outputs more negative
// - single supply turns offset path off, hi-z
// - code format follows data format select pin
// - first code channels 0-3, second 4-7
`timescale 1ns/1ps
module offset_dac_code_control #(
  parameter logic signed [2:0] TRIM_A_SIX  = 3'sd0,
  parameter logic signed [2:0] TRIM_A_FOUR = 3'sd0,
  parameter logic signed [2:0] TRIM_B_SIX  = 3'sd0,
  parameter logic signed [2:0] TRIM_B_FOUR = 3'sd0
) (
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          rst_b,
  // pins from outside the clock domain
  input  wire logic                          data_format_select,
  input  wire logic                          single_supply,
  // gain setting from the configuration logic
  input  wire offset_code_pkg::gain_sel_t    gain_request,
  // code writes from the serial port logic
  input  wire logic                          code_write,
  input  wire logic                          code_write_group,
  input  wire offset_code_pkg::offset_code_t code_write_data,
  // offset path controls
  output offset_code_pkg::offset_pair_t      offset_codes,
  output offset_code_pkg::gain_sel_t         gain_applied,
  output logic                               offset_enable,
  output logic                               amp_hiz,
  output logic                               codes_valid
);

  // ----------------------------------------------------------------
  // default code for one group
  // ----------------------------------------------------------------
  function automatic offset_code_pkg::offset_code_t default_code(
    input offset_code_pkg::gain_sel_t gain,
    input logic                       twos,
    input logic signed [2:0]          trim
  );
    offset_code_pkg::offset_code_t nominal;
    offset_code_pkg::offset_code_t trimmed;
    logic signed [2:0]             trim_held;
    // a trim of minus four would leave the three-count window,
    // so it is held at minus three
    trim_held = (trim == 3'sh4) ? 3'sh5 : trim;
    nominal = (gain == offset_code_pkg::GAIN_SIX) ? offset_code_pkg::NOMINAL_GAIN_SIX
                                                  : offset_code_pkg::NOMINAL_GAIN_FOUR;
    trimmed = nominal + offset_code_pkg::offset_code_t'(14'(signed'(trim_held)));
    default_code = twos ? (trimmed ^ offset_code_pkg::FORMAT_FLIP) : trimmed;
  endfunction : default_code

  function automatic offset_code_pkg::offset_pair_t default_pair(
    input offset_code_pkg::gain_sel_t gain,
    input logic                       twos
  );
    offset_code_pkg::offset_pair_t pair;
    if (gain == offset_code_pkg::GAIN_SIX) begin
      pair.group_a = default_code(gain, twos, TRIM_A_SIX);
      pair.group_b = default_code(gain, twos, TRIM_B_SIX);
    end else begin
      pair.group_a = default_code(gain, twos, TRIM_A_FOUR);
      pair.group_b = default_code(gain, twos, TRIM_B_FOUR);
    end
    default_pair = pair;
  endfunction : default_pair

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] reset_pipe;
  logic       rst_sync_b;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reset_pipe <= 2'b00;
    end else begin
      reset_pipe <= {reset_pipe[0], 1'b1};
    end
  end

  assign rst_sync_b = reset_pipe[1];

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] format_pipe;
  logic [2:0] supply_pipe;
  logic       format_twos;
  logic       supply_single;
  logic       next_format_twos;
  logic       next_supply_single;

  always_comb begin
    next_format_twos   = format_twos;
    next_supply_single = supply_single;
    if (format_pipe[1] == format_pipe[2]) begin
      next_format_twos = format_pipe[2];
    end
    if (supply_pipe[1] == supply_pipe[2]) begin
      next_supply_single = supply_pipe[2];
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      format_pipe   <= 3'b000;
      supply_pipe   <= 3'b000;
      format_twos   <= 1'b0;
      supply_single <= 1'b0;
    end else begin
      format_pipe   <= {format_pipe[1:0], data_format_select};
      supply_pipe   <= {supply_pipe[1:0], single_supply};
      format_twos   <= next_format_twos;
      supply_single <= next_supply_single;
    end
  end

  // ----------------------------------------------------------------
  // code control
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SETTLE,
    LOAD,
    RUN
  } ctrl_state_t;

  ctrl_state_t                   state;
  ctrl_state_t                   next_state;
  logic [1:0]                    settle_count;
  logic [1:0]                    next_settle_count;
  offset_code_pkg::offset_pair_t next_offset_codes;
  offset_code_pkg::gain_sel_t    next_gain_applied;
  logic                          next_offset_enable;
  logic                          next_amp_hiz;
  logic                          next_codes_valid;

  always_comb begin
    next_state         = state;
    next_settle_count  = settle_count;
    next_offset_codes  = offset_codes;
    next_gain_applied  = gain_applied;
    next_codes_valid   = codes_valid;
    case (state)
      SETTLE: begin
        // wait until the format and supply pins have passed the synchroniser
        next_settle_count = settle_count + 2'd1;
        if (settle_count == 2'(offset_code_pkg::SYNC_STAGES)) begin
          next_state = LOAD;
        end
      end
      LOAD: begin
        next_gain_applied = gain_request;
        next_offset_codes = default_pair(gain_request, format_twos);
        next_codes_valid  = 1'b1;
        next_state        = RUN;
      end
      RUN: begin
        if (gain_request != gain_applied) begin
          // new gain and its defaults land together; a write in this cycle is dropped
          next_gain_applied = gain_request;
          next_offset_codes = default_pair(gain_request, format_twos);
        end else if (code_write) begin
          if (code_write_group == 1'(offset_code_pkg::GROUP_A)) begin
            next_offset_codes.group_a = code_write_data;
          end else begin
            next_offset_codes.group_b = code_write_data;
          end
        end
      end
      default: begin
        next_state = SETTLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state         <= SETTLE;
      settle_count  <= 2'd0;
      offset_codes  <= '{group_b: offset_code_pkg::CODE_RESET, group_a: offset_code_pkg::CODE_RESET};
      gain_applied  <= offset_code_pkg::GAIN_SIX;
      codes_valid   <= 1'b0;
    end else begin
      state         <= next_state;
      settle_count  <= next_settle_count;
      offset_codes  <= next_offset_codes;
      gain_applied  <= next_gain_applied;
      codes_valid   <= next_codes_valid;
    end
  end

  // ----------------------------------------------------------------
  // offset path control
  // ----------------------------------------------------------------
  always_comb begin
    // path stays off until the defaults are loaded; in single-supply operation
    // the amplifier is parked in hi-z so a stored code has no effect
    next_offset_enable = (state == RUN) && !supply_single;
    next_amp_hiz       = (state != RUN) || supply_single;
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      offset_enable <= 1'b0;
      amp_hiz       <= 1'b1;
    end else begin
      offset_enable <= next_offset_enable;
      amp_hiz       <= next_amp_hiz;
    end
  end

endmodule : offset_dac_code_control

// ===== verilog/offset_code_pkg.sv
// shared constants and types for the offset code control block
package offset_code_pkg;

  // ----------------------------------------------------------------
  // code layout
  // ----------------------------------------------------------------
  localparam int          CODE_W        = 14;
  localparam int          GROUP_COUNT   = 2;
  localparam int          GROUP_A       = 0;
  localparam int          GROUP_B       = 1;
  localparam int          TRIM_W        = 3;

  // ----------------------------------------------------------------
  // nominal defaults, straight binary
  // ----------------------------------------------------------------
  localparam logic [13:0] NOMINAL_GAIN_SIX  = 14'h2666;
  localparam logic [13:0] NOMINAL_GAIN_FOUR = 14'h2AAB;
  localparam logic [13:0] FORMAT_FLIP       = 14'h2000;
  localparam logic [13:0] CODE_RESET        = 14'h0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          SYNC_STAGES   = 3;

  typedef logic [CODE_W-1:0] offset_code_t;

  typedef struct packed {
    offset_code_t group_b;
    offset_code_t group_a;
  } offset_pair_t;

  typedef enum logic {
    GAIN_FOUR,
    GAIN_SIX
  } gain_sel_t;

endpackage : offset_code_pkg

// ===== test/offset_code_chk.sv
// port assertions for the offset code control block
`timescale 1ns/1ps
module offset_code_chk (
  // clock and reset
  input wire logic                          clock,
  input wire logic                          rst_b,
  // pins
  input wire logic                          data_format_select,
  input wire logic                          single_supply,
  // gain and code writes
  input wire offset_code_pkg::gain_sel_t    gain_request,
  input wire logic                          code_write,
  input wire logic                          code_write_group,
  input wire offset_code_pkg::offset_code_t code_write_data,
  // offset path controls
  input wire offset_code_pkg::offset_pair_t offset_codes,
  input wire offset_code_pkg::gain_sel_t    gain_applied,
  input wire logic                          offset_enable,
  input wire logic                          amp_hiz,
  input wire logic                          codes_valid
);
  wire logic [13:0] nom_plain = (gain_applied == offset_code_pkg::GAIN_SIX) ? offset_code_pkg::NOMINAL_GAIN_SIX
                                                                           : offset_code_pkg::NOMINAL_GAIN_FOUR;
  wire logic [13:0] nom = data_format_select ? (nom_plain ^ offset_code_pkg::FORMAT_FLIP) : nom_plain;
  wire logic [13:0] da = offset_codes.group_a - nom;
  wire logic [13:0] db = offset_codes.group_b - nom;
  wire logic near = ((da + 14'h0003) <= 14'h0006) && ((db + 14'h0003) <= 14'h0006);
  wire logic wr = codes_valid && code_write && gain_request == gain_applied;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_write_a:
    assert property (wr && !code_write_group |=> offset_codes.group_a == $past(code_write_data))
      else $error("write a lost");
  a_write_b:
    assert property (wr && code_write_group
                     |=> offset_codes.group_b == $past(code_write_data) && $stable(offset_codes.group_a))
      else $error("write b lost");
  a_gain_takes:
    assert property (codes_valid && gain_request != gain_applied |=> gain_applied == $past(gain_request))
      else $error("gain late");
  a_reload_default:
    assert property (codes_valid && gain_request != gain_applied |=> near) else $error("no reload");
  a_reset_default:
    assert property ($rose(codes_valid) |-> near) else $error("bad default");
  a_zero_early:
    assert property (!codes_valid |-> offset_codes == 28'h000_0000) else $error("code before valid");
  a_codes_hold:
    assert property (codes_valid && !code_write && gain_request == gain_applied |=> $stable(offset_codes))
      else $error("code moved");
  a_hiz_pair:
    assert property (amp_hiz != offset_enable) else $error("hiz not inverse");
  a_single_off:
    assert property (single_supply [*6] |-> !offset_enable && amp_hiz) else $error("offset on");
endmodule : offset_code_chk

// ===== test/offset_host_model.sv
// host model issuing offset code writes
`timescale 1ns/1ps
module offset_host_model (
  input wire logic clock,
  output logic code_write,
  output logic code_write_group,
  output offset_code_pkg::offset_code_t code_write_data
);
  initial begin
    code_write = 1'b0;
    code_write_group = 1'b0;
    code_write_data = 14'h0000;
  end
  // writes only when a scenario commands one; released data shows the inverse
  task automatic write(input logic g, input offset_code_pkg::offset_code_t d);
    @(posedge clock);
    code_write <= 1'b1;
    code_write_group <= g;
    code_write_data <= d;
    @(posedge clock);
    code_write <= 1'b0;
    code_write_data <= ~d;
  endtask : write
endmodule : offset_host_model

// ===== test/tb_offset_dac_code_control.sv
// self-checking bench for the offset code control block
`timescale 1ns/1ps
module tb_offset_dac_code_control;
  logic clock, rst_b, data_format_select, single_supply, code_write, code_write_group;
  logic offset_enable, amp_hiz, codes_valid;
  offset_code_pkg::gain_sel_t gain_request, gain_applied;
  offset_code_pkg::offset_code_t code_write_data;
  offset_code_pkg::offset_pair_t offset_codes;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  offset_dac_code_control i_dut (.clock(clock), .rst_b(rst_b), .data_format_select(data_format_select),
    .single_supply(single_supply), .gain_request(gain_request), .code_write(code_write),
    .code_write_group(code_write_group), .code_write_data(code_write_data), .offset_codes(offset_codes),
    .gain_applied(gain_applied), .offset_enable(offset_enable), .amp_hiz(amp_hiz), .codes_valid(codes_valid));
  offset_host_model i_host (.clock(clock), .code_write(code_write), .code_write_group(code_write_group),
    .code_write_data(code_write_data));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic close_out();
    if (num_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic chk_code(input logic [13:0] act, input logic [13:0] exp, input int tol);
    logic ok;
    ok = 1'b0;
    samples_checked++;
    for (int k = -tol; k <= tol; k++)
      if (act === exp + 14'(k))
        ok = 1'b1;
    if (!ok) begin
      num_errors++;
      $display("Error %0t code %h expected %h", $time, act, exp);
    end
  endtask : chk_code
  task automatic chk_bit(input logic act, input logic exp);
    samples_checked++;
    if (act !== exp) begin
      num_errors++;
      $display("Error %0t flag %b expected %b", $time, act, exp);
    end
  endtask : chk_bit
  function automatic logic [13:0] nom(input offset_code_pkg::gain_sel_t g, input logic f);
    return (g == offset_code_pkg::GAIN_SIX ? 14'h2666 : 14'h2AAB) ^ {f, 13'h0000};
  endfunction : nom
  task automatic t_reset(input logic f, input offset_code_pkg::gain_sel_t g);
    @(posedge clock);
    rst_b <= 1'b0;
    data_format_select <= f;
    gain_request <= g;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    for (int k = 0; k < 12 && codes_valid !== 1'b1; k++)
      @(negedge clock);
    chk_bit(codes_valid, 1'b1);
    chk_code(offset_codes.group_a, nom(g, f), 3);
    chk_code(offset_codes.group_b, nom(g, f), 3);
  endtask : t_reset
  task automatic t_write();
    i_host.write(1'b0, 14'h3FFF);
    i_host.write(1'b1, 14'h0000);
    @(negedge clock);
    chk_code(offset_codes.group_a, 14'h3FFF, 0);
    chk_code(offset_codes.group_b, 14'h0000, 0);
  endtask : t_write
  task automatic t_gain(input offset_code_pkg::gain_sel_t g);
    fork
      i_host.write(1'b0, 14'h1234);
      begin
        @(posedge clock);
        gain_request <= g;
      end
    join
    @(negedge clock);
    chk_bit(gain_applied, g);
    chk_code(offset_codes.group_a, nom(g, data_format_select), 3);
    chk_code(offset_codes.group_b, nom(g, data_format_select), 3);
  endtask : t_gain
  task automatic t_supply(input logic s);
    @(posedge clock);
    single_supply <= s;
    repeat (7) @(negedge clock);
    chk_bit(offset_enable, !s);
    chk_bit(amp_hiz, s);
  endtask : t_supply
  initial begin
    rst_b = 1'b0;
    data_format_select = 1'b0;
    single_supply = 1'b0;
    gain_request = offset_code_pkg::GAIN_SIX;
    t_reset(1'b0, offset_code_pkg::GAIN_SIX);
    t_write();
    t_gain(offset_code_pkg::GAIN_FOUR);
    t_gain(offset_code_pkg::GAIN_SIX);
    t_supply(1'b1);
    t_supply(1'b0);
    t_reset(1'b1, offset_code_pkg::GAIN_FOUR);
    t_gain(offset_code_pkg::GAIN_SIX);
    close_out();
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 1000) begin
      num_errors++;
      close_out();
    end
  end
endmodule : tb_offset_dac_code_control
bind offset_dac_code_control offset_code_chk i_chk (.clock(clock), .rst_b(rst_b),
  .data_format_select(data_format_select),
  .single_supply(single_supply), .gain_request(gain_request), .code_write(code_write),
  .code_write_group(code_write_group), .code_write_data(code_write_data), .offset_codes(offset_codes),
  .gain_applied(gain_applied), .offset_enable(offset_enable), .amp_hiz(amp_hiz), .codes_valid(codes_valid));
